//--- rtl/usr_suspend_resume.sv
// usb suspend/resume sequencer with command/data parallel port
// How it works
// - idle over 3 ms means suspend
// - suspend flag set; irq if enabled
// - live bus-suspended status bit readable
// - falling go-suspend bit enters suspend
// - powered-off: suspend pin, clocks off 2ms
// - resume on K 20ms, wakeup, chip-select
// - chip-select wake needs enable and vbus
// - remote wake drives K for 10ms
// - clocks distributed only after oscillator settles
// - wake clears suspend pin, sets resume flag
// - normal operation within 15 ms
// - writes locked after wake until aa37
// - pull-up connect and internal/external select
// - config bit selects powered-off behaviour
// - a0 high: byte is command code
// - a0 low: data phase, lsb first
// - endpoint config write 20-2f, read 30-3f
// - address b6/b7, mode b8/b9, one byte
// - hw config ba/bb two, enables c2/c3 four
`timescale 1ns/1ps
`include "usr_defines.svh"
module usr_suspend_resume #(
  parameter int unsigned IDLE_CYC   = `USR_MS2CYC(`USR_T_IDLE_MS),
  parameter int unsigned OFF_CYC    = `USR_MS2CYC(`USR_T_OFF_MS),
  parameter int unsigned KRES_CYC   = `USR_MS2CYC(`USR_T_KRES_MS),
  parameter int unsigned KDRV_CYC   = `USR_MS2CYC(`USR_T_KDRV_MS),
  parameter int unsigned SETTLE_CYC = `USR_MS2CYC(`USR_T_SETTLE_MS),
  parameter int unsigned NORMAL_CYC = `USR_MS2CYC(`USR_T_NORMAL_MS)
) (
  input  wire logic              clk_sys_i,               // system clock
  input  wire logic              reset_i,                 // sync reset
  input  wire usr_pkg::usr_pin_s pins_i,                  // raw pins
  output logic [7:0]             data_o,                  // read data
  output logic                   data_oe_o,               // read data enable
  output logic                   irq_o,                   // interrupt
  output logic                   suspend_o,               // power-off pin
  output logic                   osc_en_o,                // oscillator/pll on
  output logic                   clk_dist_o,              // clocks routed
  output logic                   usb_dp_o,                // dp drive value
  output logic                   usb_dm_o,                // dm drive value
  output logic                   usb_oe_o,                // dp/dm drive enable
  output logic                   pullup_int_o,            // internal pull-up on
  output logic                   pullup_ext_o,            // external pull-up on
  output logic                   suspend_detected_flag_o, // sticky suspend
  output logic                   resume_detected_flag_o,  // sticky resume
  output logic                   bus_suspended_status_o,  // live bus state
  output logic                   write_locked_o           // writes blocked
);
  import usr_pkg::*;
  usr_pin_s   p1, p2, p3;
  usr_state_e state;
  usr_cnt_t   idle_cnt, kres_cnt, kdrv_cnt, seq_cnt;
  logic [7:0] cmd, dev_addr, mode, rd_byte, unlock_lo;
  logic [15:0] hwcfg;
  logic [31:0] ie;
  logic [7:0] ep_cfg [16];
  logic [1:0] idx;
  logic       cmd_take, dat_take, rd_start, rd_end, wr_ok, sel;
  logic       bus_j, bus_k, idle_long, idle_q, idle_evt, go_q, go_fall;
  logic       wake_k, wake_pin, wake_cs, wake_any, wake_done, flag_clr;
  logic       go_to_suspend, soft_pullup_connect, external_pullup_select;
  logic       powered_off_select, clock_run_enable, chipselect_wake_enable;
  logic       suspend_irq_enable, resume_irq_enable;
  // two-stage pin synchroniser, p3 only for edge detection
  always_ff @(posedge clk_sys_i) begin
    p1 <= pins_i;
    p2 <= p1;
    p3 <= p2;
  end
  assign go_to_suspend          = mode[`USR_MODE_GO_SUSPEND];
  assign soft_pullup_connect    = mode[`USR_MODE_PULLUP_CONN];
  assign external_pullup_select = hwcfg[`USR_HW_EXT_PULLUP];
  assign powered_off_select     = hwcfg[`USR_HW_POWERED_OFF];
  assign clock_run_enable       = hwcfg[`USR_HW_CLOCK_RUN];
  assign chipselect_wake_enable = hwcfg[`USR_HW_CS_WAKE];
  assign suspend_irq_enable     = ie[`USR_IE_SUSPEND];
  assign resume_irq_enable      = ie[`USR_IE_RESUME];
  // parallel port strobes
  assign sel      = !p2.cs_n;
  assign cmd_take = sel && p2.wr_n && !p3.wr_n && p2.a0;
  assign dat_take = sel && p2.wr_n && !p3.wr_n && !p2.a0;
  assign rd_start = sel && !p2.rd_n && p3.rd_n && !p2.a0;
  assign rd_end   = p2.rd_n && !p3.rd_n && !p2.a0;
  assign wr_ok    = dat_take && !write_locked_o;
  assign flag_clr = rd_end && cmd == `USR_CMD_INT_RD && idx == 2'h0; // clear once read
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cmd <= 8'h00;
      idx <= 2'h0;
    end else if (cmd_take) begin
      cmd <= p2.data;
      idx <= 2'h0;
    end else if (dat_take || rd_end) begin
      idx <= idx + 2'h1;
    end
  end
  // endpoint configuration entries
  for (genvar e = 0; e < 16; e++) begin : g_ep
    always_ff @(posedge clk_sys_i) begin
      if (reset_i || (cmd_take && p2.data == `USR_CMD_RESET)) begin
        ep_cfg[e] <= `USR_RST_EP;
      end else if (wr_ok && cmd == {`USR_CMD_EP_WR, 4'(e)}) begin
        ep_cfg[e] <= p2.data;
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || (cmd_take && p2.data == `USR_CMD_RESET)) begin
      dev_addr <= `USR_RST_ADDR;
      mode     <= `USR_RST_MODE;
      hwcfg    <= `USR_RST_HW;
      ie       <= `USR_RST_IE;
    end else begin
      if (wr_ok && cmd == `USR_CMD_ADDR_WR) begin
        dev_addr <= p2.data;
      end
      if (wr_ok && cmd == `USR_CMD_MODE_WR) begin
        mode <= p2.data;
      end
      if (wr_ok && cmd == `USR_CMD_HW_WR) begin
        hwcfg[idx[0]*8 +: 8] <= p2.data;
      end
      if (wr_ok && cmd == `USR_CMD_IE_WR) begin
        ie[idx*8 +: 8] <= p2.data;
      end
      if (wake_done) begin
        hwcfg[`USR_HW_CLOCK_RUN] <= 1'b1;
      end
    end
  end
  // write lock: wake sets, unlock code clears, set wins
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      write_locked_o <= 1'b0;
      unlock_lo      <= 8'h00;
    end else begin
      if (dat_take && cmd == `USR_CMD_UNLOCK && idx == 2'h0) begin
        unlock_lo <= p2.data;
      end
      if (wake_done) begin
        write_locked_o <= 1'b1;
      end else if (dat_take && cmd == `USR_CMD_UNLOCK && idx == 2'h1
                   && {p2.data, unlock_lo} == `USR_UNLOCK_CODE) begin
        write_locked_o <= 1'b0;
      end
    end
  end
  always_comb begin
    rd_byte = 8'h00;
    if (cmd[7:4] == `USR_CMD_EP_RD) begin
      rd_byte = ep_cfg[cmd[3:0]];
    end else begin
      case (cmd)
        `USR_CMD_ADDR_RD: rd_byte = dev_addr;
        `USR_CMD_MODE_RD: rd_byte = mode;
        `USR_CMD_HW_RD:   rd_byte = hwcfg[idx[0]*8 +: 8];
        `USR_CMD_IE_RD:   rd_byte = ie[idx*8 +: 8];
        `USR_CMD_INT_RD:  rd_byte = (idx == 2'h0) ? {5'h00, bus_suspended_status_o,
                            resume_detected_flag_o, suspend_detected_flag_o} : 8'h00;
        default:          rd_byte = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      data_o    <= 8'h00;
      data_oe_o <= 1'b0;
    end else if (rd_start) begin
      data_o    <= rd_byte;
      data_oe_o <= 1'b1;
    end else if (p2.rd_n || p2.cs_n) begin
      data_oe_o <= 1'b0;
    end
  end
  // bus idle detection
  assign bus_j     = p2.dp && !p2.dm;
  assign bus_k     = !p2.dp && p2.dm;
  assign idle_long = idle_cnt == usr_cnt_t'(IDLE_CYC);
  assign idle_evt  = idle_long && !idle_q;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !bus_j || usb_oe_o) begin
      idle_cnt <= '0;
    end else if (!idle_long) begin
      idle_cnt <= idle_cnt + usr_cnt_t'(1);
    end
  end
  // edge history of idle and go-suspend
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      idle_q                 <= 1'b0;
      bus_suspended_status_o <= 1'b0;
      go_q                   <= 1'b0;
    end else begin
      idle_q                 <= idle_long;
      bus_suspended_status_o <= idle_long;
      go_q                   <= go_to_suspend;
    end
  end
  // resume detection while asleep
  assign wake_k   = kres_cnt == usr_cnt_t'(KRES_CYC);
  assign wake_pin = p2.wakeup;
  assign wake_cs  = p2.cs_n == 1'b0 && chipselect_wake_enable && p2.vbus;
  assign wake_any = wake_k || wake_pin || wake_cs;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || state != st_sleep || !bus_k) begin
      kres_cnt <= '0;
    end else if (!wake_k) begin
      kres_cnt <= kres_cnt + usr_cnt_t'(1);
    end
  end
  assign go_fall   = go_q && !go_to_suspend;
  assign wake_done = state == st_wake && seq_cnt == usr_cnt_t'(SETTLE_CYC);
  // power sequence
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state      <= st_awake;
      seq_cnt    <= '0;
      suspend_o  <= 1'b0;
      osc_en_o   <= 1'b1;
      clk_dist_o <= 1'b1;
    end else begin
      case (state)
        st_awake: begin
          osc_en_o   <= 1'b1;
          clk_dist_o <= clock_run_enable;
          seq_cnt    <= '0;
          if (go_fall) begin
            state <= st_sleep;
          end
        end
        st_sleep: begin
          suspend_o <= powered_off_select;
          if (seq_cnt != usr_cnt_t'(OFF_CYC)) begin
            seq_cnt <= seq_cnt + usr_cnt_t'(1);
          end
          if (powered_off_select) begin
            osc_en_o   <= seq_cnt != usr_cnt_t'(OFF_CYC);
            clk_dist_o <= seq_cnt != usr_cnt_t'(OFF_CYC);
          end else begin
            osc_en_o   <= clock_run_enable;
            clk_dist_o <= clock_run_enable;
          end
          if (wake_any) begin
            state      <= st_wake;
            seq_cnt    <= '0;
            osc_en_o   <= 1'b1;
            clk_dist_o <= 1'b0;
          end
        end
        st_wake: begin
          seq_cnt <= seq_cnt + usr_cnt_t'(1);
          if (wake_done) begin
            clk_dist_o <= 1'b1;
            suspend_o  <= 1'b0;
            state      <= st_awake;
          end
        end
        default: state <= st_awake;
      endcase
    end
  end
  // remote wake k-state drive
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      kdrv_cnt <= '0;
      usb_oe_o <= 1'b0;
      usb_dp_o <= 1'b0;
      usb_dm_o <= 1'b0;
    end else if (state == st_sleep && (wake_pin || wake_cs) && !wake_k) begin
      kdrv_cnt <= usr_cnt_t'(KDRV_CYC);
      usb_oe_o <= 1'b1;
      usb_dp_o <= 1'b0;
      usb_dm_o <= 1'b1;
    end else if (kdrv_cnt != '0) begin
      kdrv_cnt <= kdrv_cnt - usr_cnt_t'(1);
      usb_oe_o <= kdrv_cnt != usr_cnt_t'(1);
    end
  end
  // sticky flags, set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      suspend_detected_flag_o <= 1'b0;
      resume_detected_flag_o  <= 1'b0;
    end else begin
      if (idle_evt && state == st_awake) begin
        suspend_detected_flag_o <= 1'b1;
      end else if (flag_clr) begin
        suspend_detected_flag_o <= 1'b0;
      end
      if (wake_done) begin
        resume_detected_flag_o <= 1'b1;
      end else if (flag_clr) begin
        resume_detected_flag_o <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_o        <= 1'b0;
      pullup_int_o <= 1'b0;
      pullup_ext_o <= 1'b0;
    end else begin
      irq_o <= (suspend_detected_flag_o && suspend_irq_enable)
             || (resume_detected_flag_o && resume_irq_enable);
      pullup_int_o <= soft_pullup_connect && !external_pullup_select;
      pullup_ext_o <= soft_pullup_connect && external_pullup_select;
    end
  end
  AST_SUSP_FLAG: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    idle_evt && state == st_awake |=> suspend_detected_flag_o) else $error("suspend lost");
  AST_IRQ: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !suspend_irq_enable && !resume_irq_enable |=> !irq_o) else $error("irq not masked");
  AST_GO_SUSP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == st_awake && go_q && !go_to_suspend |=> state == st_sleep)
    else $error("no suspend entry");
  AST_OFF: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == st_sleep && powered_off_select && seq_cnt == usr_cnt_t'(OFF_CYC) && !wake_any
    |=> !osc_en_o && suspend_o) else $error("clocks not off");
  AST_CS_WAKE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == st_sleep && !chipselect_wake_enable && !p2.wakeup && !wake_k
    |=> state == st_sleep) else $error("bad wake");
  AST_KDRV: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(usb_oe_o) |-> kdrv_cnt == usr_cnt_t'(KDRV_CYC) && usb_dm_o && !usb_dp_o)
    else $error("bad k drive");
  AST_NORMAL: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == st_wake |-> seq_cnt < usr_cnt_t'(NORMAL_CYC)) else $error("wake too long");
  AST_LOCK: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    write_locked_o && dat_take && cmd == `USR_CMD_MODE_WR |=> $stable(mode))
    else $error("locked write");
  AST_PULLUP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !(pullup_int_o && pullup_ext_o)) else $error("two pull-ups");
endmodule : usr_suspend_resume

//--- rtl/usr_defines.svh
// constants for the usb suspend and resume controller
`ifndef USR_DEFINES_SVH
`define USR_DEFINES_SVH
`define USR_CLK_KHZ          20000
`define USR_MS2CYC(ms)       ((ms) * `USR_CLK_KHZ)
`define USR_T_IDLE_MS        3
`define USR_T_OFF_MS         2
`define USR_T_KRES_MS        20
`define USR_T_KDRV_MS        10
`define USR_T_SETTLE_MS      2
`define USR_T_NORMAL_MS      15
`define USR_CNT_W            19
`define USR_CMD_EP_WR        4'h2
`define USR_CMD_EP_RD        4'h3
`define USR_CMD_ADDR_WR      8'hb6
`define USR_CMD_ADDR_RD      8'hb7
`define USR_CMD_MODE_WR      8'hb8
`define USR_CMD_MODE_RD      8'hb9
`define USR_CMD_HW_WR        8'hba
`define USR_CMD_HW_RD        8'hbb
`define USR_CMD_IE_WR        8'hc2
`define USR_CMD_IE_RD        8'hc3
`define USR_CMD_INT_RD       8'hc0
`define USR_CMD_UNLOCK       8'hb0
`define USR_CMD_RESET        8'hf6
`define USR_UNLOCK_CODE      16'haa37
`define USR_MODE_PULLUP_CONN 0
`define USR_MODE_GO_SUSPEND  5
`define USR_HW_EXT_PULLUP    2
`define USR_HW_POWERED_OFF   3
`define USR_HW_CLOCK_RUN     4
`define USR_HW_CS_WAKE       5
`define USR_IE_SUSPEND       0
`define USR_IE_RESUME        1
`define USR_RST_ADDR         8'h00
`define USR_RST_MODE         8'h00
`define USR_RST_HW           16'h0010
`define USR_RST_IE           32'h0000_0000
`define USR_RST_EP           8'h00
`endif

//--- rtl/usr_pkg.sv
// types for the usb suspend and resume controller
`include "usr_defines.svh"
package usr_pkg;
  typedef logic [`USR_CNT_W-1:0] usr_cnt_t;
  typedef enum logic [1:0] {st_awake, st_sleep, st_wake} usr_state_e;
  typedef struct packed {
    logic [7:0] data;
    logic       cs_n;
    logic       a0;
    logic       rd_n;
    logic       wr_n;
    logic       wakeup;
    logic       vbus;
    logic       dp;
    logic       dm;
  } usr_pin_s;
endpackage : usr_pkg

//--- test/usr_host_model.sv
// usb host side model driving the bus lines
`timescale 1ns/1ps
module usr_host_model (
  input  wire logic       clk_sys_i, // bench clock
  input  wire logic [1:0] mode_i,    // 0 idle, 1 resume k, 2 traffic
  output logic            dp_o,      // host dp level
  output logic            dm_o       // host dm level
);
  logic tog;
  initial tog = 1'b0;
  always @(posedge clk_sys_i) begin
    tog <= ~tog;
  end
  always_comb begin
    case (mode_i)
      2'd0: {dp_o, dm_o} = 2'b10;
      2'd1: {dp_o, dm_o} = 2'b01;
      default: {dp_o, dm_o} = {tog, 1'b0};
    endcase
  end
endmodule : usr_host_model

//--- test/tb_top.sv
// self-checking bench for the usb suspend and resume controller
`timescale 1ns/1ps
module tb_top;
  import usr_pkg::*;
  localparam int IDLE = 20, OFF = 10, KRES = 30, KDRV = 25, SETTLE = 8, NORM = 40;
  logic       clk_sys_i, reset_i, cs_n, a0, rd_n, wr_n, wakeup, vbus;
  logic [7:0] d_q, data_o;
  logic       data_oe_o, irq_o, suspend_o, osc_en_o, clk_dist_o, dp_o, dm_o, oe_o;
  logic       pu_int, pu_ext, sus_f, res_f, bus_st, locked, host_dp, host_dm;
  logic [1:0] host_mode;
  usr_pin_s   pins;
  int         errors, checks;
  // bus level: device drive wins over the host
  assign pins = {d_q, cs_n, a0, rd_n, wr_n, wakeup, vbus,
                 oe_o ? dp_o : host_dp, oe_o ? dm_o : host_dm};
  usr_host_model u_host (.clk_sys_i(clk_sys_i), .mode_i(host_mode), .dp_o(host_dp),
                         .dm_o(host_dm));
  usr_suspend_resume #(.IDLE_CYC(IDLE), .OFF_CYC(OFF), .KRES_CYC(KRES), .KDRV_CYC(KDRV),
    .SETTLE_CYC(SETTLE), .NORMAL_CYC(NORM)) u_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .pins_i(pins), .data_o(data_o),
    .data_oe_o(data_oe_o), .irq_o(irq_o), .suspend_o(suspend_o), .osc_en_o(osc_en_o),
    .clk_dist_o(clk_dist_o), .usb_dp_o(dp_o), .usb_dm_o(dm_o), .usb_oe_o(oe_o),
    .pullup_int_o(pu_int), .pullup_ext_o(pu_ext), .suspend_detected_flag_o(sus_f),
    .resume_detected_flag_o(res_f), .bus_suspended_status_o(bus_st),
    .write_locked_o(locked));
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #5;
  endtask : step
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic a, input logic [7:0] d);
    {a0, d_q, cs_n, wr_n} = {a, d, 2'b00};
    step(3);
    wr_n = 1'b1;
    step(3);
    cs_n = 1'b1;
    step(1);
  endtask : wr
  task automatic wrc(input logic [7:0] c, input int n, input logic [31:0] v);
    wr(1'b1, c);
    for (int i = 0; i < n; i++) wr(1'b0, v[8*i+:8]);
  endtask : wrc
  task automatic rdc(input logic [7:0] c, input int n, input logic [31:0] e, input string nm);
    wr(1'b1, c);
    for (int i = 0; i < n; i++) begin
      {a0, cs_n, rd_n} = 3'b000;
      step(4);
      chk(nm, {7'h00, data_oe_o, data_o}, {8'h01, e[8*i+:8]});
      rd_n = 1'b1;
      step(4);
      cs_n = 1'b1;
      step(1);
    end
  endtask : rdc
  // unlock, configure, wait for idle suspend, then toggle go-suspend
  task automatic sleep(input logic [15:0] hw);
    wrc(8'hb0, 2, 32'haa37);
    wrc(8'hba, 2, {16'h0, hw});
    host_mode = 2'd2;
    step(4);
    host_mode = 2'd0;
    step(IDLE + 6);
    chk("status", {bus_st, irq_o}, 2'b11);
    rdc(8'hc0, 1, 32'h05, "intr");
    wrc(8'hb8, 1, 32'h21);
    chk("early", suspend_o, 1'b0);
    wrc(8'hb8, 1, 32'h01);
    step(1);
    chk("susp_pin", suspend_o, hw[3]);
  endtask : sleep
  task automatic wk(input int kexp, input int nmin, input int nmax);
    int k, n, bad;
    k = 0;
    n = 0;
    bad = 0;
    for (int i = 0; i < 80; i++) begin
      step(1);
      if (oe_o === 1'b1) begin
        k++;
        if ({dp_o, dm_o} !== 2'b01) bad++;
      end
      if (clk_dist_o !== 1'b1) n = i + 1;
    end
    chk("kdrive", k, kexp);
    chk("kstate", bad, 0);
    chk("settle", n >= nmin && n <= nmax, 1'b1);
    chk("wake", {suspend_o, res_f, irq_o, locked, osc_en_o}, 5'b01111);
    host_mode = 2'd2;
    step(2);
    rdc(8'hc0, 1, 32'h02, "intr");
  endtask : wk
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    conclude();
  end
  initial begin
    errors = 0;
    checks = 0;
    {reset_i, cs_n, a0, rd_n, wr_n, wakeup, vbus, d_q, host_mode} = {6'h3e, 1'b0, 8'h00, 2'd2};
    step(20);
    reset_i = 1'b0;
    step(4);
    chk("rst_out", {osc_en_o, clk_dist_o, suspend_o, locked}, 4'b1100);
    rdc(8'hbb, 2, 32'h0010, "hw_rst");
    rdc(8'hc3, 4, 32'h0, "ie_rst");
    rdc(8'hb9, 1, 32'h0, "mode_rst");
    $display("test reset done");
    wrc(8'hb8, 1, 32'h01);
    chk("pull_int", {pu_int, pu_ext}, 2'b10);
    wrc(8'hba, 2, 32'h0014);
    chk("pull_ext", {pu_int, pu_ext}, 2'b01);
    rdc(8'hbb, 2, 32'h0014, "hw");
    wrc(8'hb6, 1, 32'h5a);
    rdc(8'hb7, 1, 32'h5a, "addr");
    wrc(8'hc2, 4, 32'h0403_0200);
    rdc(8'hc3, 4, 32'h0403_0200, "ie");
    for (int i = 0; i < 16; i++) wrc(8'h20 + 8'(i), 1, 32'h40 + i);
    for (int i = 0; i < 16; i++) rdc(8'h30 + 8'(i), 1, 32'h40 + i, "ep");
    wrc(8'hc2, 4, 32'h0);
    wrc(8'hf6, 0, 32'h0);
    rdc(8'hb7, 1, 32'h00, "addr_rst");
    rdc(8'h35, 1, 32'h00, "ep_rst");
    $display("test registers done");
    host_mode = 2'd0;
    step(IDLE - 5);
    host_mode = 2'd2;
    step(3);
    host_mode = 2'd0;
    step(IDLE - 5);
    chk("restart", {bus_st, sus_f}, 2'b00);
    step(12);
    chk("suspend", {bus_st, sus_f, irq_o}, 3'b110);
    wrc(8'hc2, 4, 32'h1);
    chk("irq_on", irq_o, 1'b1);
    rdc(8'hc0, 1, 32'h05, "intr");
    chk("irq_clr", irq_o, 1'b0);
    wrc(8'hc2, 4, 32'h3);
    $display("test suspend detect done");
    sleep(16'h0008);
    chk("osc_hold", osc_en_o, 1'b1);
    step(OFF + 4);
    chk("osc_off", {osc_en_o, clk_dist_o}, 2'b00);
    host_mode = 2'd2;
    wakeup = 1'b1;
    wk(KDRV, SETTLE, NORM);
    wakeup = 1'b0;
    wrc(8'hb8, 1, 32'h00);
    rdc(8'hb9, 1, 32'h01, "locked");
    wrc(8'hb0, 2, 32'haa37);
    chk("unlock", locked, 1'b0);
    wrc(8'hb8, 1, 32'h00);
    rdc(8'hb9, 1, 32'h00, "mode");
    $display("test powered off wake done");
    sleep(16'h0020);
    step(4);
    chk("clk_stop", osc_en_o, 1'b0);
    cs_n = 1'b0;
    step(20);
    chk("no_vbus", clk_dist_o, 1'b0);
    cs_n = 1'b1;
    host_mode = 2'd1;
    wk(0, KRES, KRES + NORM + 4);
    $display("test host resume done");
    sleep(16'h0020);
    vbus = 1'b1;
    host_mode = 2'd2;
    step(4);
    cs_n = 1'b0;
    wk(KDRV, SETTLE, NORM);
    cs_n = 1'b1;
    $display("test chip select wake done");
    conclude();
  end
endmodule : tb_top
